// File: core/rmps_pkg.sv
// Purpose: Shared constants for the reduced-interface PHY-side timing block
// Assumes: One clock, clk_in, that stands in for the reference clock
// Notes:   Latencies are held in tenths of a bit time
package rmps_pkg;

  localparam int CLK_PERIOD_NS  = 50;
  localparam int REF_PERIOD_NS  = 20;
  localparam int BIT_TIME_NS    = 10;
  localparam int TX_LAT_TENTHS  = 170;
  localparam int CRS_ON_TENTHS  = 185;
  localparam int CRS_OFF_TENTHS = 270;
  localparam int RX_LAT_TENTHS  = 380;
  localparam int LOOP_MAX_NS    = 2000;
  localparam int HOLD_10M_CYC   = 10;
  localparam logic [1:0] EB_DEFAULT = 2'h1;

  // Bit-time latency to whole cycles, rounded up, never below one
  function automatic int lat_cyc(input int tenths);
    int c;
    c = (tenths * BIT_TIME_NS + 10 * CLK_PERIOD_NS - 1) / (10 * CLK_PERIOD_NS);
    return (c < 1) ? 1 : c;
  endfunction

  localparam int TX_LAT_CYC   = lat_cyc(TX_LAT_TENTHS);
  localparam int CRS_ON_CYC   = lat_cyc(CRS_ON_TENTHS);
  localparam int CRS_OFF_CYC  = lat_cyc(CRS_OFF_TENTHS);
  localparam int RX_LAT_CYC   = lat_cyc(RX_LAT_TENTHS);
  localparam int LOOP_MAX_CYC = LOOP_MAX_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    RMPS_IDLE    = 2'h0,
    RMPS_CARRIER = 2'h1,
    RMPS_DRAIN   = 2'h3
  } rmps_rx_state_t;

endpackage

// File: core/rmps_pipe_if.sv
// Purpose: Carrier for a word moving between the block and its delay lines
// Assumes: Same clock on both ends
// Notes:   Width set per instance
`timescale 1ns/1ps
`default_nettype none
interface rmps_pipe_if #(parameter int W = 1);
  logic [W-1:0] d;
  modport src (output d);
  modport snk (input d);
endinterface
`default_nettype wire

// File: core/rmps_delay.sv
// Purpose: Fixed-length registered delay line
// Assumes: DEPTH of one or more
// Notes:   Output comes straight from the last stage
`timescale 1ns/1ps
`default_nettype none
module rmps_delay
  import rmps_pkg::*;
#(
  parameter int W     = 1,
  parameter int DEPTH = 1
) (
  // Clock and reset
  input  wire logic  clk_in,
  input  wire logic  sys_rst_in,
  // Word in and out
  rmps_pipe_if.snk   in_if,
  rmps_pipe_if.src   out_if
);

  logic [W-1:0] stage_r [DEPTH];

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_r[i] <= '0;
      end
    end else begin
      stage_r[0] <= in_if.d;
      for (int i = 1; i < DEPTH; i++) begin
        stage_r[i] <= stage_r[i-1];
      end
    end
  end

  assign out_if.d = stage_r[DEPTH-1];

endmodule // rmps_delay
`default_nettype wire

// File: core/rmps_pace.sv
// Purpose: Dibit pacing strobe and slow transmit clock phase
// Assumes: Mode input is steady between frames
// Notes:   Strobe every cycle at 100 Mb/s, every tenth at 10 Mb/s
`timescale 1ns/1ps
`default_nettype none
module rmps_pace
  import rmps_pkg::*;
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // Mode
  input  wire logic speed_10m_in,
  // Pacing
  output logic      strobe_out,
  output logic      phase_out
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       phase_r;
  logic       wrap_w;

  assign wrap_w     = (cnt_r == 4'(HOLD_10M_CYC - 1));
  assign cnt_nxt    = (wrap_w || !speed_10m_in) ? 4'h0 : cnt_r + 4'h1;
  assign strobe_out = !speed_10m_in || (cnt_r == 4'h0);
  assign phase_out  = phase_r;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r   <= 4'h0;
      phase_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      phase_r <= speed_10m_in && (cnt_nxt < 4'(HOLD_10M_CYC / 2));
    end
  end

endmodule // rmps_pace
`default_nettype wire

// File: core/rmps_phy_side.sv
// Purpose: PHY-side timing of the reduced interface toward a MAC
// Assumes: clk_in is the reference clock; MAC pins are synchronous to it
// Notes:   Line side is abstracted to dibit streams with an activity level
`timescale 1ns/1ps
`default_nettype none
module rmps_phy_side
  import rmps_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  // Mode
  input  wire logic       speed_10m_in,
  input  wire logic       loopback_in,
  // MAC transmit
  input  wire logic [1:0] txd_in,
  input  wire logic       tx_en_in,
  // MAC receive
  output logic      [1:0] rxd_out,
  output logic            crs_dv_out,
  output logic            rx_dv_out,
  output logic            rx_er_out,
  // Clocks out
  output logic            tx_clk_out,
  output logic            derived_clk_out,
  // Line transmit
  output logic      [1:0] line_txd_out,
  output logic            line_tx_en_out,
  // Line receive
  input  wire logic [1:0] line_rxd_in,
  input  wire logic       line_rx_act_in,
  input  wire logic       line_rx_err_in
);

  // Pacing
  logic strobe_w;
  logic slow_phase_w;

  rmps_pace u_pace (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .speed_10m_in (speed_10m_in),
    .strobe_out   (strobe_w),
    .phase_out    (slow_phase_w)
  );

  // Transmit capture
  logic [1:0] txd_r;
  logic       tx_en_r;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      txd_r   <= 2'h0;
      tx_en_r <= 1'b0;
    end else if (strobe_w) begin
      txd_r   <= txd_in;
      tx_en_r <= tx_en_in;
    end
  end

  // Transmit latency to the line
  rmps_pipe_if #(.W(3)) tx_in_if ();
  rmps_pipe_if #(.W(3)) tx_out_if ();

  assign tx_in_if.d = {tx_en_r, txd_r};

  rmps_delay #(
    .W     (3),
    .DEPTH (TX_LAT_CYC)
  ) u_tx_dly (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .in_if      (tx_in_if),
    .out_if     (tx_out_if)
  );

  assign line_tx_en_out = tx_out_if.d[2];
  assign line_txd_out   = tx_out_if.d[1:0];

  // Receive source: line, or transmit path in 10 Mb/s loopback
  logic       loop_w;
  logic       src_act_w;
  logic [1:0] src_d_w;
  logic       src_err_w;

  assign loop_w    = loopback_in && speed_10m_in;
  assign src_act_w = loop_w ? tx_en_r : line_rx_act_in;
  assign src_d_w   = loop_w ? txd_r : line_rxd_in;
  assign src_err_w = loop_w ? 1'b0 : line_rx_err_in;

  // Start and end of stream events
  logic act_d_r;
  logic rise_w;
  logic fall_w;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      act_d_r <= 1'b0;
    end else begin
      act_d_r <= src_act_w;
    end
  end

  assign rise_w = src_act_w && !act_d_r;
  assign fall_w = !src_act_w && act_d_r;

  // Receive data latency
  rmps_pipe_if #(.W(4)) rx_in_if ();
  rmps_pipe_if #(.W(4)) rx_out_if ();

  assign rx_in_if.d = {src_act_w, src_err_w, src_d_w};

  rmps_delay #(
    .W     (4),
    .DEPTH (RX_LAT_CYC)
  ) u_rx_dly (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .in_if      (rx_in_if),
    .out_if     (rx_out_if)
  );

  // Carrier on latency
  rmps_pipe_if #(.W(1)) on_in_if ();
  rmps_pipe_if #(.W(1)) on_out_if ();

  assign on_in_if.d = rise_w;

  rmps_delay #(
    .W     (1),
    .DEPTH (CRS_ON_CYC)
  ) u_on_dly (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .in_if      (on_in_if),
    .out_if     (on_out_if)
  );

  // Carrier off latency
  rmps_pipe_if #(.W(1)) off_in_if ();
  rmps_pipe_if #(.W(1)) off_out_if ();

  assign off_in_if.d = fall_w;

  rmps_delay #(
    .W     (1),
    .DEPTH (CRS_OFF_CYC)
  ) u_off_dly (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .in_if      (off_in_if),
    .out_if     (off_out_if)
  );

  // Pipe outputs
  logic       on_evt_w;
  logic       off_evt_w;
  logic       pipe_vld_w;
  logic       pipe_err_w;
  logic [1:0] pipe_d_w;

  assign on_evt_w   = on_out_if.d[0];
  assign off_evt_w  = off_out_if.d[0];
  assign pipe_vld_w = rx_out_if.d[3];
  assign pipe_err_w = rx_out_if.d[2];
  assign pipe_d_w   = rx_out_if.d[1:0];

  // Carrier state
  rmps_rx_state_t state_r;
  rmps_rx_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RMPS_IDLE: begin
        if (on_evt_w) begin
          state_nxt = RMPS_CARRIER;
        end
      end
      RMPS_CARRIER: begin
        if (off_evt_w) begin
          state_nxt = RMPS_DRAIN;
        end
      end
      RMPS_DRAIN: begin
        if (on_evt_w) begin
          state_nxt = RMPS_CARRIER;
        end else if (strobe_w && !pipe_vld_w) begin
          state_nxt = RMPS_IDLE;
        end
      end
      default: begin
        state_nxt = RMPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= RMPS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Receive launch registers
  logic [1:0] rxd_r;
  logic       rx_dv_r;
  logic       rx_er_r;
  logic       crs_hold_r;
  logic       crs_hold_nxt;

  always_comb begin
    crs_hold_nxt = crs_hold_r;
    case (state_nxt)
      RMPS_CARRIER: begin
        crs_hold_nxt = 1'b1;
      end
      RMPS_DRAIN: begin
        if (state_r != RMPS_DRAIN) begin
          crs_hold_nxt = 1'b0;
        end else if (strobe_w) begin
          crs_hold_nxt = !crs_hold_r;
        end
      end
      default: begin
        crs_hold_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rxd_r      <= 2'h0;
      rx_dv_r    <= 1'b0;
      rx_er_r    <= 1'b0;
      crs_hold_r <= 1'b0;
    end else begin
      crs_hold_r <= crs_hold_nxt;
      if (strobe_w) begin
        rxd_r   <= pipe_vld_w ? pipe_d_w : 2'h0;
        rx_er_r <= pipe_vld_w && pipe_err_w;
        rx_dv_r <= pipe_vld_w;
      end
    end
  end

  // Carrier asserts straight from the on event in RMPS_IDLE, no launch edge
  assign crs_dv_out = crs_hold_r || (state_r == RMPS_IDLE && on_evt_w);
  assign rxd_out    = rxd_r;
  assign rx_dv_out  = rx_dv_r;
  assign rx_er_out  = rx_er_r;

  // Derived clocks
  logic div2_r;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div2_r <= 1'b0;
    end else begin
      div2_r <= !div2_r;
    end
  end

  assign derived_clk_out = div2_r;
  assign tx_clk_out      = speed_10m_in ? slow_phase_w : div2_r;

endmodule // rmps_phy_side
`default_nettype wire

// File: verification/rmps_mac_model.sv
// Purpose: MAC partner driving transmit dibits
// Assumes: Drives on falling edges
// Notes:   Carrier/valid is synchronised before use
`timescale 1ns/1ps
`default_nettype none
module rmps_mac_model (
  // Clock, reset, control
  input  wire logic       clk_in, sys_rst_in, burst_in, crs_dv_in,
  // Transmit pins
  output logic      [1:0] txd_out,
  output logic            tx_en_out,
  // Synchronised carrier
  output logic            crs_sync_out
);
  initial {txd_out, tx_en_out} = 3'h0;
  always @(negedge clk_in) begin
    txd_out   <= sys_rst_in ? 2'h0 : 2'($urandom);
    tx_en_out <= burst_in & !sys_rst_in;
  end
  always_ff @(posedge clk_in) crs_sync_out <= crs_dv_in;
endmodule // rmps_mac_model
`default_nettype wire

// File: verification/rmps_phy_side_chk.sv
// Purpose: Port timing checks
// Assumes: One clock domain
// Notes:   Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module rmps_phy_side_chk
  import rmps_pkg::*;
(
  // Clock, reset, modes
  input wire logic       clk_in, sys_rst_in, speed_10m_in, loopback_in,
  // Transmit side
  input wire logic [1:0] txd_in, line_txd_out,
  input wire logic       tx_en_in, line_tx_en_out, tx_clk_out, derived_clk_out,
  // Receive side
  input wire logic [1:0] rxd_out, line_rxd_in,
  input wire logic       crs_dv_out, rx_dv_out, rx_er_out, line_rx_act_in, line_rx_err_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_derived_toggle: assert property (
    $past(!sys_rst_in) |-> derived_clk_out != $past(derived_clk_out)) else $error("no toggle");
  a_tx_latency: assert property (
    (!sys_rst_in && !speed_10m_in) [*6] |->
    {line_tx_en_out, line_txd_out} == $past({tx_en_in, txd_in}, 5)) else $error("tx delay");
  a_txclk_follow: assert property (
    (!speed_10m_in) [*3] |-> tx_clk_out == derived_clk_out) else $error("tx clock");
  a_crs_on: assert property (
    $rose(line_rx_act_in) && !crs_dv_out |-> !crs_dv_out [*4] ##[1:2] crs_dv_out)
    else $error("carrier on");
  a_crs_off: assert property (
    $fell(line_rx_act_in) |-> crs_dv_out [*6] ##[1:2] !crs_dv_out) else $error("carrier off");
  a_rxdv_latency: assert property (
    $rose(line_rx_act_in) && !speed_10m_in |-> !rx_dv_out [*8] ##[1:3] rx_dv_out)
    else $error("rx valid");
  a_rxd_idle: assert property (
    !rx_dv_out |-> rxd_out == 2'h0) else $error("rx data idle");
  a_loop_bound: assert property (
    $rose(tx_en_in) && loopback_in && speed_10m_in |-> ##[1:40] rx_dv_out)
    else $error("loopback");
  c_frame: cover property ($rose(crs_dv_out));
  c_drain: cover property ($fell(line_rx_act_in) ##8 rx_dv_out);
  c_loop: cover property (loopback_in && rx_dv_out);
endmodule // rmps_phy_side_chk
bind rmps_phy_side rmps_phy_side_chk u_chk (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .speed_10m_in(speed_10m_in),
  .loopback_in(loopback_in), .txd_in(txd_in), .line_txd_out(line_txd_out),
  .tx_en_in(tx_en_in), .line_tx_en_out(line_tx_en_out), .tx_clk_out(tx_clk_out),
  .derived_clk_out(derived_clk_out), .rxd_out(rxd_out), .line_rxd_in(line_rxd_in),
  .crs_dv_out(crs_dv_out), .rx_dv_out(rx_dv_out), .rx_er_out(rx_er_out),
  .line_rx_act_in(line_rx_act_in), .line_rx_err_in(line_rx_err_in));
`default_nettype wire

// File: verification/rmps_phy_side_tb.sv
// Purpose: Self-checking bench
// Assumes: 100 Mb/s frames, then 10 Mb/s loopback
// Notes:   Model keeps a history of sampled inputs
`timescale 1ns/1ps
`default_nettype none
module rmps_phy_side_tb;
  import rmps_pkg::*;
  logic       clk_in, sys_rst_in, speed_10m_in, loopback_in, tx_burst, cmp_en;
  logic       tx_en_in, crs_dv_out, rx_dv_out, rx_er_out, tx_clk_out, derived_clk_out;
  logic       line_tx_en_out, line_rx_act_in, line_rx_err_in, crs_sync;
  logic [1:0] txd_in, rxd_out, line_txd_out, line_rxd_in;
  logic [6:0] hist[$];
  int         errors, total_checks, n, hi;

  rmps_phy_side u_rmps_phy_side (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .speed_10m_in(speed_10m_in),
    .loopback_in(loopback_in), .txd_in(txd_in), .tx_en_in(tx_en_in), .rxd_out(rxd_out),
    .crs_dv_out(crs_dv_out), .rx_dv_out(rx_dv_out), .rx_er_out(rx_er_out),
    .tx_clk_out(tx_clk_out), .derived_clk_out(derived_clk_out),
    .line_txd_out(line_txd_out), .line_tx_en_out(line_tx_en_out),
    .line_rxd_in(line_rxd_in), .line_rx_act_in(line_rx_act_in),
    .line_rx_err_in(line_rx_err_in));
  rmps_mac_model u_rmps_mac_model (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .burst_in(tx_burst), .crs_dv_in(crs_dv_out),
    .txd_out(txd_in), .tx_en_out(tx_en_in), .crs_sync_out(crs_sync));

  initial begin
    clk_in = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk_in = ~clk_in;
  end

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Carrier/valid seen k cycles ago: async on, held, off, one drain toggle
  function automatic logic crs_exp(input int k);
    return hist[k + CRS_ON_CYC - 1][3] | hist[k + CRS_OFF_CYC][3] |
           (hist[k + CRS_OFF_CYC + 2][3] & !hist[k + CRS_OFF_CYC + 1][3]);
  endfunction

  task automatic report_and_stop();
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic frame(input int len, input bit errs);
    @(negedge clk_in);
    line_rx_act_in <= 1'b1;
    tx_burst <= 1'($urandom);
    repeat (len) begin
      line_rxd_in <= 2'($urandom);
      line_rx_err_in <= errs & ($urandom_range(7) == 0);
      @(negedge clk_in);
    end
    line_rx_act_in <= 1'b0;
    line_rx_err_in <= 1'b0;
    repeat (15) @(negedge clk_in);
  endtask

  always @(posedge clk_in) begin
    if (sys_rst_in) hist.delete();
    else hist.push_front({tx_en_in, txd_in, line_rx_act_in, line_rx_err_in, line_rxd_in});
    if (hist.size() > 12) void'(hist.pop_back());
  end

  always @(negedge clk_in) begin
    if (cmp_en && hist.size() > 9) begin
      chk({1'b0, line_tx_en_out, line_txd_out}, {1'b0, hist[TX_LAT_CYC][6:4]});
      chk({3'h0, rx_dv_out}, {3'h0, hist[RX_LAT_CYC][3]});
      chk({2'h0, rxd_out}, hist[RX_LAT_CYC][3] ? {2'h0, hist[RX_LAT_CYC][1:0]} : 4'h0);
      if (hist[RX_LAT_CYC][3]) chk({3'h0, rx_er_out}, {3'h0, hist[RX_LAT_CYC][2]});
      chk({3'h0, crs_dv_out}, {3'h0, crs_exp(0)});
      chk({3'h0, crs_sync}, {3'h0, crs_exp(1)});
    end
  end

  initial begin
    #(CLK_PERIOD_NS * 10000);
    errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(10811));
    {sys_rst_in, speed_10m_in, loopback_in, tx_burst, cmp_en} = 5'h10;
    {line_rx_act_in, line_rx_err_in, line_rxd_in} = 4'h0;
    errors = 0;
    total_checks = 0;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in) sys_rst_in <= 1'b0;
    cmp_en <= 1'b1;
    for (int f = 0; f < 40; f++) frame(20 + $urandom_range(30), f[0]);
    sys_rst_in <= 1'b1;
    tx_burst <= 1'b0;
    @(negedge clk_in) chk({rx_dv_out, crs_dv_out, line_tx_en_out, derived_clk_out}, 4'h0);
    sys_rst_in <= 1'b0;
    speed_10m_in <= 1'b1;
    loopback_in <= 1'b1;
    cmp_en <= 1'b0;
    repeat (3) @(negedge clk_in);
    tx_burst <= 1'b1;
    n = 0;
    while (rx_dv_out !== 1'b1 && n < 60) begin
      @(negedge clk_in);
      n++;
    end
    chk(4'(n <= LOOP_MAX_CYC), 4'h1);
    hi = 0;
    repeat (20) begin
      @(negedge clk_in);
      hi += int'(tx_clk_out);
    end
    chk(4'(hi), 4'hA);
    report_and_stop();
  end
endmodule // rmps_phy_side_tb
`default_nettype wire
